// *** hdl/bcc_regs.sv ***
// Purpose: per-port back-channel config registers and self-test tally
// Assumes: register bus from the local I2C slave, one-cycle strobes
// Notes: remote writes come from the control channel and cannot touch keep-alive
`timescale 1ns/1ps
`default_nettype none
module bcc_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Power-down pin and strap
  input wire logic i_power_down_pin,
  input wire logic [2:0] i_rate_strap,
  // Register bus
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_remote,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Self-test error events
  input wire logic i_bist_clr,
  input wire logic i_bist_err,
  // Port 0 controls
  output logic o_fwd_all_0,
  output logic o_fwd_match_0,
  output logic o_ack_all_0,
  output logic o_bc_enable_0,
  output logic o_crc_on_0,
  output logic [2:0] o_rate_0,
  output logic o_rate_bad_0,
  output logic o_settling_0,
  // Port 1 controls
  output logic o_fwd_all_1,
  output logic o_fwd_match_1,
  output logic o_ack_all_1,
  output logic o_bc_enable_1,
  output logic o_crc_on_1,
  output logic [2:0] o_rate_1,
  output logic o_rate_bad_1,
  output logic o_settling_1
);
  import bcc_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] cfg_mem [BCC_NPORTS];
  logic [7:0] port_sel;
  logic [7:0] tally;
  logic pdp_q;
  bcc_state_t state;
  bcc_state_t next_state;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic sel_idx;
  wire logic hit_cfg;
  wire logic hit_sel;
  wire logic hit_tally;
  wire logic pdp_rise;
  wire logic [7:0] wr_mask;
  wire logic [7:0] next_cfg;
  wire logic [7:0] strap_cfg;
  wire logic [7:0] next_tally;
  wire logic [7:0] rd_mux;

  // Port select low bit picks the copy
  assign sel_idx = port_sel[0];
  assign hit_cfg = (i_addr == BCC_ADDR_CONFIG);
  assign hit_sel = (i_addr == BCC_ADDR_PORT_SEL);
  assign hit_tally = (i_addr == BCC_ADDR_TALLY);
  // Pin already high out of reset counts as a rise, so the strap rate lands
  assign pdp_rise = i_power_down_pin & ~pdp_q;
  assign wr_mask = i_remote ? ~BCC_KEEP_MASK : 8'hff;
  assign next_cfg = (cfg_mem[sel_idx] & ~wr_mask) | (i_wdata & wr_mask);
  assign strap_cfg = (BACK_CHANNEL_CONFIG_RESET & ~BCC_RATE_MASK) | {5'h00, i_rate_strap};
  // Saturate so a long run never wraps to a small count
  assign next_tally = i_bist_clr ? (i_bist_err ? 8'h01 : 8'h00) :
                      ((i_bist_err && tally != 8'hff) ? tally + 8'h01 : tally);
  // Unmapped reads return zero
  assign rd_mux = hit_cfg ? cfg_mem[sel_idx] : hit_sel ? port_sel : hit_tally ? tally : 8'h00;

  always_comb begin
    next_state = state;
    case (state)
      BCC_ST_IDLE: begin
        if (pdp_rise) begin
          next_state = BCC_ST_LOAD;
        end
      end
      BCC_ST_LOAD: begin
        next_state = BCC_ST_RUN;
      end
      BCC_ST_RUN: begin
        if (!i_power_down_pin) begin
          next_state = BCC_ST_IDLE;
        end
      end
      default: begin
        next_state = BCC_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= BCC_ST_IDLE;
      pdp_q <= 1'b0;
    end else begin
      state <= next_state;
      pdp_q <= i_power_down_pin;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int p = 0; p < BCC_NPORTS; p++) begin
        cfg_mem[p] <= BACK_CHANNEL_CONFIG_RESET;
      end
    end else if (state == BCC_ST_LOAD) begin
      for (int p = 0; p < BCC_NPORTS; p++) begin
        cfg_mem[p] <= strap_cfg;
      end
    end else if (i_wr && hit_cfg) begin
      cfg_mem[sel_idx] <= next_cfg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_sel <= BCC_PORT_SEL_RESET;
    end else if (i_wr && hit_sel) begin
      port_sel <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tally <= BCC_TALLY_RESET;
    end else begin
      tally <= next_tally;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : o_rdata;
      o_rvalid <= i_rd;
    end
  end

  // ----------------------------------------
  // Per-port decode
  // ----------------------------------------
  bcc_cfg_if cfg0 ();
  bcc_cfg_if cfg1 ();
  assign cfg0.cfg = cfg_mem[0];
  assign cfg1.cfg = cfg_mem[1];

  bcc_decode u_dec0 (
    .cfg_if(cfg0)
  );
  bcc_decode u_dec1 (
    .cfg_if(cfg1)
  );

  wire logic settle0;
  wire logic settle1;
  bcc_settle u_set0 (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_rate(cfg0.rate),
    .o_settling(settle0)
  );
  bcc_settle u_set1 (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_rate(cfg1.rate),
    .o_settling(settle1)
  );

  // ----------------------------------------
  // Next output values
  // ----------------------------------------
  wire logic next_fwd_all_0;
  wire logic next_fwd_match_0;
  wire logic next_ack_all_0;
  wire logic next_bc_enable_0;
  wire logic next_crc_on_0;
  wire logic [2:0] next_rate_0;
  wire logic next_rate_bad_0;
  wire logic next_settling_0;
  wire logic next_fwd_all_1;
  wire logic next_fwd_match_1;
  wire logic next_ack_all_1;
  wire logic next_bc_enable_1;
  wire logic next_crc_on_1;
  wire logic [2:0] next_rate_1;
  wire logic next_rate_bad_1;
  wire logic next_settling_1;

  assign next_fwd_all_0 = cfg0.cfg[BCC_FWD_ALL_BIT];
  assign next_fwd_match_0 = cfg0.cfg[BCC_FWD_MATCH_BIT];
  assign next_ack_all_0 = cfg0.cfg[BCC_ACK_ALL_BIT];
  assign next_bc_enable_0 = cfg0.bc_enable;
  assign next_crc_on_0 = cfg0.crc_on;
  assign next_rate_0 = cfg0.rate;
  // Reserved codes kept as written, only flagged
  assign next_rate_bad_0 = ~cfg0.rate_ok;
  assign next_settling_0 = settle0;

  assign next_fwd_all_1 = cfg1.cfg[BCC_FWD_ALL_BIT];
  assign next_fwd_match_1 = cfg1.cfg[BCC_FWD_MATCH_BIT];
  assign next_ack_all_1 = cfg1.cfg[BCC_ACK_ALL_BIT];
  assign next_bc_enable_1 = cfg1.bc_enable;
  assign next_crc_on_1 = cfg1.crc_on;
  assign next_rate_1 = cfg1.rate;
  // Reserved codes kept as written, only flagged
  assign next_rate_bad_1 = ~cfg1.rate_ok;
  assign next_settling_1 = settle1;

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Link gating bits of port 0
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fwd_all_0 <= 1'b0;
      o_fwd_match_0 <= 1'b0;
      o_ack_all_0 <= 1'b0;
      o_bc_enable_0 <= 1'b1;
      o_crc_on_0 <= 1'b1;
    end else begin
      o_fwd_all_0 <= next_fwd_all_0;
      o_fwd_match_0 <= next_fwd_match_0;
      o_ack_all_0 <= next_ack_all_0;
      o_bc_enable_0 <= next_bc_enable_0;
      o_crc_on_0 <= next_crc_on_0;
    end
  end

  // Rate group of port 0
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rate_0 <= 3'h0;
      o_rate_bad_0 <= 1'b0;
      o_settling_0 <= 1'b0;
    end else begin
      o_rate_0 <= next_rate_0;
      o_rate_bad_0 <= next_rate_bad_0;
      o_settling_0 <= next_settling_0;
    end
  end

  // Link gating bits of port 1
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fwd_all_1 <= 1'b0;
      o_fwd_match_1 <= 1'b0;
      o_ack_all_1 <= 1'b0;
      o_bc_enable_1 <= 1'b1;
      o_crc_on_1 <= 1'b1;
    end else begin
      o_fwd_all_1 <= next_fwd_all_1;
      o_fwd_match_1 <= next_fwd_match_1;
      o_ack_all_1 <= next_ack_all_1;
      o_bc_enable_1 <= next_bc_enable_1;
      o_crc_on_1 <= next_crc_on_1;
    end
  end

  // Rate group of port 1
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rate_1 <= 3'h0;
      o_rate_bad_1 <= 1'b0;
      o_settling_1 <= 1'b0;
    end else begin
      o_rate_1 <= next_rate_1;
      o_rate_bad_1 <= next_rate_bad_1;
      o_settling_1 <= next_settling_1;
    end
  end
endmodule // bcc_regs
`default_nettype wire

// *** hdl/bcc_pkg.sv ***
// Purpose: constants and types for the back-channel config register bank
// Assumes: 8-bit register bus from a local I2C slave front end
// Notes: two receive ports, selected by the port-select register
// What this block does
// - Read-only 8-bit self-test error tally reports errors seen in self test.
// - Each receive port has its own config copy, chosen by port select.
// - Forward-all bit set forwards every local I2C transaction; resets to zero.
// - Forward-on-match bit forwards only transactions matching the address decoder.
// - Acknowledge-all bit makes the device acknowledge every I2C write itself.
// - Keep-alive bit set, reset one, keeps the back channel always enabled.
// - Keep-alive clear enables back channel only while a forwarding bit is set.
// - Keep-alive bit is written only by the local host, not the link.
// - CRC generation bit, reset one, appends CRC to back-channel traffic.
// - Three-bit rate field selects 2.5, 10, 25, 50 or 100 Mbps; others reserved.
// - Rate field reset value is loaded from a strap when power-down pin rises.
// - Back channel may show a short error burst after a rate change.
package bcc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] BCC_ADDR_PORT_SEL = 8'h4c;
  localparam logic [7:0] BCC_ADDR_TALLY = 8'h57;
  localparam logic [7:0] BCC_ADDR_CONFIG = 8'h58;
  localparam int BCC_NPORTS = 2;
  // ----------------------------------------
  // Field layout and resets
  // ----------------------------------------
  localparam int BCC_FWD_ALL_BIT = 7;
  localparam int BCC_FWD_MATCH_BIT = 6;
  localparam int BCC_ACK_ALL_BIT = 5;
  localparam int BCC_KEEP_ALIVE_BIT = 4;
  localparam int BCC_CRC_BIT = 3;
  localparam logic [7:0] BACK_CHANNEL_CONFIG_RESET = 8'h18;
  localparam logic [7:0] BCC_TALLY_RESET = 8'h00;
  localparam logic [7:0] BCC_PORT_SEL_RESET = 8'h00;
  localparam logic [7:0] BCC_KEEP_MASK = 8'h10;
  localparam logic [7:0] BCC_RATE_MASK = 8'h07;
  // ----------------------------------------
  // Rate codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    BCC_RATE_2M5 = 3'h0,
    BCC_RATE_10M = 3'h2,
    BCC_RATE_25M = 3'h5,
    BCC_RATE_50M = 3'h6,
    BCC_RATE_100M = 3'h7
  } bcc_rate_t;
  // Settle window after rate change, in ns and cycles at 125 MHz
  localparam int BCC_CLK_PERIOD_NS = 8;
  localparam int BCC_SETTLE_NS = 800;
  localparam int BCC_SETTLE_CYC = (BCC_SETTLE_NS + BCC_CLK_PERIOD_NS - 1) / BCC_CLK_PERIOD_NS;
  // Strap loader states
  typedef enum logic [2:0] {
    BCC_ST_IDLE = 3'b001,
    BCC_ST_LOAD = 3'b010,
    BCC_ST_RUN = 3'b100
  } bcc_state_t;

  function automatic logic bcc_rate_valid(input logic [2:0] code);
    bcc_rate_valid = (code == BCC_RATE_2M5) || (code == BCC_RATE_10M) || (code == BCC_RATE_25M) ||
                     (code == BCC_RATE_50M) || (code == BCC_RATE_100M);
  endfunction
endpackage

// *** hdl/bcc_cfg_if.sv ***
// Purpose: carrier of one port's decoded config between modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface bcc_cfg_if;
  logic [7:0] cfg;
  logic bc_enable;
  logic crc_on;
  logic [2:0] rate;
  logic rate_ok;
  modport src (output cfg);
  modport dec (input cfg, output bc_enable, crc_on, rate, rate_ok);
  modport use_side (input bc_enable, crc_on, rate, rate_ok, cfg);
endinterface
`default_nettype wire

// *** hdl/bcc_decode.sv ***
// Purpose: decode one port config byte into back-channel controls
// Assumes: combinational only
// Notes: reserved rate codes flagged, not remapped
`timescale 1ns/1ps
`default_nettype none
module bcc_decode (
  // Config carrier
  bcc_cfg_if.dec cfg_if
);
  import bcc_pkg::*;
  wire logic keep_on;
  wire logic fwd_any;
  assign keep_on = cfg_if.cfg[BCC_KEEP_ALIVE_BIT];
  assign fwd_any = cfg_if.cfg[BCC_FWD_ALL_BIT] | cfg_if.cfg[BCC_FWD_MATCH_BIT];
  assign cfg_if.bc_enable = keep_on | fwd_any;
  assign cfg_if.crc_on = cfg_if.cfg[BCC_CRC_BIT];
  assign cfg_if.rate = cfg_if.cfg[2:0];
  assign cfg_if.rate_ok = bcc_rate_valid(cfg_if.cfg[2:0]);
endmodule // bcc_decode
`default_nettype wire

// *** hdl/bcc_settle.sv ***
// Purpose: flags the error-prone window after a rate change
// Assumes: rate input held stable between changes
// Notes: counter restarts on every change
`timescale 1ns/1ps
`default_nettype none
module bcc_settle (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Rate in
  input wire logic [2:0] i_rate,
  // Window out
  output logic o_settling
);
  import bcc_pkg::*;
  logic [2:0] last_rate;
  logic [7:0] cnt;
  wire logic changed;
  wire logic [7:0] next_cnt;
  assign changed = (i_rate != last_rate);
  assign next_cnt = changed ? 8'(BCC_SETTLE_CYC) : ((cnt != 8'h00) ? cnt - 8'h01 : 8'h00);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_rate <= 3'h0;
      cnt <= 8'h00;
      o_settling <= 1'b0;
    end else begin
      last_rate <= i_rate;
      cnt <= next_cnt;
      o_settling <= (next_cnt != 8'h00);
    end
  end
endmodule // bcc_settle
`default_nettype wire

// *** sim/bcc_remote_ser.sv ***
// Purpose: remote serializer model issuing control-channel writes
// Assumes: remote writes always target the config register
// Notes: data line toggles every cycle once released
`timescale 1ns/1ps
`default_nettype none
module bcc_remote_ser (
  // Clock
  input wire logic i_clk,
  // Command from bench
  input wire logic i_go,
  input wire logic [7:0] i_data,
  // Request out
  output logic o_wr,
  output logic [7:0] o_wdata
);
  // auto-ack raised a cycle before any remote write
  logic auto_ack = 1'b0;
  always_ff @(posedge i_clk) begin
    auto_ack <= i_go;
    o_wr <= auto_ack;
    o_wdata <= auto_ack ? i_data : ~o_wdata;
  end
endmodule // bcc_remote_ser
`default_nettype wire

// *** sim/bcc_regs_chk.sv ***
// Purpose: port assertions for the back-channel config bank
// Assumes: one clock, port select followed from bus writes
// Notes: writes in the strap-load cycle are left out
`timescale 1ns/1ps
`default_nettype none
module bcc_regs_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Pin, bus, self test
  input wire logic i_power_down_pin,
  input wire logic [2:0] i_rate_strap,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_remote,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_bist_clr,
  input wire logic i_bist_err,
  // Port controls
  input wire logic o_fwd_all_0,
  input wire logic o_fwd_match_0,
  input wire logic o_ack_all_0,
  input wire logic o_bc_enable_0,
  input wire logic o_crc_on_0,
  input wire logic [2:0] o_rate_0,
  input wire logic o_rate_bad_0,
  input wire logic o_settling_0,
  input wire logic o_fwd_all_1,
  input wire logic [2:0] o_rate_1
);
  import bcc_pkg::*;
  logic sel, pin_q, ld;
  logic [7:0] tly;
  wire logic rise = i_power_down_pin && !pin_q;
  wire logic wr0 = i_wr && i_addr == BCC_ADDR_CONFIG && !sel && !ld;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel <= 1'b0;
      pin_q <= 1'b0;
      ld <= 1'b0;
      tly <= 8'h00;
    end else begin
      pin_q <= i_power_down_pin;
      ld <= rise;
      if (i_wr && i_addr == BCC_ADDR_PORT_SEL) sel <= i_wdata[0];
      if (i_bist_clr) tly <= {7'h00, i_bist_err};
      else if (i_bist_err && tly != 8'hff) tly <= tly + 8'h01;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_tly;
    i_rd && i_addr == BCC_ADDR_TALLY |=> o_rvalid && o_rdata == $past(tly);
  endproperty
  a_tly: assert property (p_tly) else $error("tally read");
  property p_fld;
    wr0 |-> ##2 {o_fwd_all_0, o_fwd_match_0, o_ack_all_0, 1'b0, o_crc_on_0, o_rate_0} == ($past(i_wdata, 2) & 8'hef);
  endproperty
  a_fld: assert property (p_fld) else $error("config fields");
  property p_en;
    wr0 && !i_remote |-> ##2 o_bc_enable_0 == |($past(i_wdata, 2) & 8'hd0);
  endproperty
  a_en: assert property (p_en) else $error("back channel enable");
  property p_keep;
    wr0 && i_remote && o_bc_enable_0 && !o_fwd_all_0 && !o_fwd_match_0 && !$past(i_wr) |-> ##2 o_bc_enable_0;
  endproperty
  a_keep: assert property (p_keep) else $error("remote keep-alive");
  property p_iso;
    wr0 ##1 !i_wr |=> $stable({o_fwd_all_1, o_rate_1});
  endproperty
  a_iso: assert property (p_iso) else $error("port isolation");
  property p_strap;
    rise |-> ##3 o_rate_0 == i_rate_strap && o_rate_1 == i_rate_strap && o_crc_on_0 && !o_fwd_all_0;
  endproperty
  a_strap: assert property (p_strap) else $error("strap load");
  property p_settle;
    $changed(o_rate_0) |-> ##[0:1] o_settling_0;
  endproperty
  a_settle: assert property (p_settle) else $error("settle window");
  property p_bad;
    o_rate_bad_0 == (o_rate_0 == 3'h1 || o_rate_0 == 3'h3 || o_rate_0 == 3'h4);
  endproperty
  a_bad: assert property (p_bad) else $error("reserved rate flag");
  c_rem: cover property (wr0 && i_remote);
  c_strap: cover property (rise);
  c_tly: cover property (i_rd && i_addr == BCC_ADDR_TALLY);
endmodule // bcc_regs_chk
bind bcc_regs bcc_regs_chk u_chk (.*);
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the back-channel config bank
// Assumes: local bus driven here, remote writes from the model
// Notes: settle window waited out at full length
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bcc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic pdp = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, clr = 1'b0, err = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [7:0] addr = 8'h00, wd = 8'h00, gd = 8'h00, r_wd, rdata;
  logic r_wr, rvalid, fa0, fm0, aa0, be0, cr0, rb0, st0, fa1, fm1, aa1, be1, cr1, rb1, st1;
  logic [2:0] ra0, ra1;
  logic [7:0] fw [4] = '{8'h40, 8'h80, 8'h10, 8'h00};
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  always #4 i_clk = ~i_clk;
  bcc_remote_ser i_ser (.i_clk(i_clk), .i_go(go), .i_data(gd), .o_wr(r_wr), .o_wdata(r_wd));
  bcc_regs i_dut (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_power_down_pin(pdp),
    .i_rate_strap(strap),
    .i_wr(wr | r_wr),
    .i_rd(rd),
    .i_remote(r_wr),
    .i_addr(r_wr ? BCC_ADDR_CONFIG : addr),
    .i_wdata(r_wr ? r_wd : wd),
    .o_rdata(rdata),
    .o_rvalid(rvalid),
    .i_bist_clr(clr),
    .i_bist_err(err),
    .o_fwd_all_0(fa0),
    .o_fwd_match_0(fm0),
    .o_ack_all_0(aa0),
    .o_bc_enable_0(be0),
    .o_crc_on_0(cr0),
    .o_rate_0(ra0),
    .o_rate_bad_0(rb0),
    .o_settling_0(st0),
    .o_fwd_all_1(fa1),
    .o_fwd_match_1(fm1),
    .o_ack_all_1(aa1),
    .o_bc_enable_1(be1),
    .o_crc_on_1(cr1),
    .o_rate_1(ra1),
    .o_rate_bad_1(rb1),
    .o_settling_1(st1)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic wc(input logic [7:0] a, input logic [7:0] d);
    w(a, d);
    @(posedge i_clk);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task automatic rem(input logic [7:0] d);
    @(posedge i_clk);
    go <= 1'b1;
    gd <= d;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling well above the run length
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rc(BCC_ADDR_CONFIG, 8'h18);
    rc(8'h59, 8'h00);
    repeat (3) begin
      @(posedge i_clk);
      err <= 1'b1;
      @(posedge i_clk);
      err <= 1'b0;
    end
    w(BCC_ADDR_TALLY, 8'h55);
    rc(BCC_ADDR_TALLY, 8'h03);
    @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    rc(BCC_ADDR_TALLY, 8'h00);
    $display("tally test done");
    wc(BCC_ADDR_CONFIG, 8'he7);
    chk({fa0, fm0, aa0, be0, cr0, ra0}, 8'hf7);
    w(BCC_ADDR_PORT_SEL, 8'h01);
    rc(BCC_ADDR_CONFIG, 8'h18);
    wc(BCC_ADDR_CONFIG, 8'h2a);
    chk({fa1, fm1, aa1, be1, cr1, ra1}, 8'h2a);
    @(posedge i_clk);
    #1;
    chk({6'h00, rb1, st1}, 8'h01);
    w(BCC_ADDR_PORT_SEL, 8'h00);
    rc(BCC_ADDR_CONFIG, 8'he7);
    $display("port test done");
    for (int i = 0; i < 8; i++) begin
      wc(BCC_ADDR_CONFIG, 8'h08 | i[7:0]);
      chk({2'h0, be0, cr0, rb0, ra0}, {4'h1, i == 1 || i == 3 || i == 4, i[2:0]});
    end
    foreach (fw[k]) begin
      wc(BCC_ADDR_CONFIG, fw[k]);
      chk({fa0, fm0, 5'h00, be0}, {fw[k][7:6], 5'h00, |(fw[k] & 8'hd0)});
    end
    $display("field test done");
    wc(BCC_ADDR_CONFIG, 8'h10);
    rem(8'h07);
    rc(BCC_ADDR_CONFIG, 8'h17);
    wc(BCC_ADDR_CONFIG, 8'h00);
    rem(8'h1f);
    rc(BCC_ADDR_CONFIG, 8'h0f);
    $display("remote test done");
    @(posedge i_clk);
    strap <= 3'h6;
    pdp <= 1'b0;
    repeat (2) @(posedge i_clk);
    pdp <= 1'b1;
    repeat (4) @(posedge i_clk);
    rc(BCC_ADDR_CONFIG, 8'h1e);
    w(BCC_ADDR_PORT_SEL, 8'h01);
    rc(BCC_ADDR_CONFIG, 8'h1e);
    w(BCC_ADDR_PORT_SEL, 8'h00);
    repeat (110) @(posedge i_clk);
    #1;
    chk({7'h00, st0}, 8'h00);
    wc(BCC_ADDR_CONFIG, 8'h1f);
    @(posedge i_clk);
    #1;
    chk({7'h00, st0}, 8'h01);
    $display("strap and settle test done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
